// ### verilog/sebf_regs.vh
// Function
// R1 - respond only when all three chip-selects match
// R2 - eight devices share bus via chip-select levels
// R3 - unconnected chip-select pin compares as low
// R4 - master changes data only while clock low
// R5 - data change during clock high: START/STOP
// R6 - guard low: whole array readable and writable
// R7 - guard high: writes inhibited, reads unaffected
// R8 - master makes clock, START, STOP; device slave
// R9 - transfer direction follows master's read/write bit
// R10 - self-timed write cycle ends within 5 ms
// R11 - transmit: data changes 300 ns after clock fall
// R12 - suppress line pulses shorter than 50 ns
// R13 - control byte: type, chip-selects, read/write bit
// R14 - no acknowledge while write cycle runs
// R15 - page write wraps six low address bits
// R16 - guard sampled at STOP of each write
// R17 - lines pass synchroniser before edge detection
// R18 - reset releases data line, idles until START
`ifndef SEBF_REGS_VH
`define SEBF_REGS_VH

// ------------------------------------------------------------
// timing figures and derived cycle counts
// ------------------------------------------------------------
`define SEBF_CLK_NS 40
`define SEBF_SPIKE_NS 50
`define SEBF_TX_HOLD_NS 300
`define SEBF_WC_MS 5
`define SEBF_NS_PER_MS 1000000
// least times round up
`define SEBF_SPIKE_CYC ((`SEBF_SPIKE_NS + `SEBF_CLK_NS - 1) / `SEBF_CLK_NS)
`define SEBF_HOLD_CYC ((`SEBF_TX_HOLD_NS + `SEBF_CLK_NS - 1) / `SEBF_CLK_NS)
// longest time rounds down
`define SEBF_WC_CYC (`SEBF_WC_MS * `SEBF_NS_PER_MS / `SEBF_CLK_NS)
`define SEBF_WC_W 17
`define SEBF_HOLD_W 4
`define SEBF_FLT_W 2

// ------------------------------------------------------------
// control byte and address layout
// ------------------------------------------------------------
`define SEBF_RW_BIT 0
`define SEBF_CS_LSB 1
`define SEBF_CS_MSB 3
`define SEBF_TYPE_LSB 4
`define SEBF_TYPE_MSB 7
`define SEBF_ADDR_W 14
`define SEBF_ADDR_HI_W 6
`define SEBF_PAGE_W 6
`define SEBF_BITS_PER_BYTE 4'h8
`define SEBF_LAST_TX_BIT 4'h7

// byte position within a command
`define SEBF_BYTE_CTRL 2'h0
`define SEBF_BYTE_AHI 2'h1
`define SEBF_BYTE_ALO 2'h2
`define SEBF_BYTE_DATA 2'h3

// synchroniser input lanes
`define SEBF_LN_SCL 0
`define SEBF_LN_SDA 1
`define SEBF_LN_CS_LSB 2
`define SEBF_LN_CS_MSB 4
`define SEBF_LN_WG 5
`define SEBF_LANES 6
// both bus lines idle high
`define SEBF_SYNC_INIT 6'h03

`endif

// ### verilog/sebf_slave_front.v
`timescale 1ns/100ps
`include "sebf_regs.vh"

module sebf_slave_front #(
	// arbitrary device type code, not tied to any real part
	parameter [3:0] DEV_TYPE = 4'h5,
	// write cycle length in cycles; shorten in simulation
	parameter WC_CYCLES = `SEBF_WC_CYC
) (
	input wire ref_clk,
	input wire reset,
	input wire scl_pin,
	input wire sda_pin_in,
	output wire sda_pin_out,
	output wire sda_pin_oe,
	input wire chip_sel_pin_0,
	input wire chip_sel_pin_1,
	input wire chip_sel_pin_2,
	input wire write_guard_pin,
	output wire wr_valid,
	input wire wr_ready,
	output wire [`SEBF_ADDR_W-1:0] wr_addr,
	output wire [7:0] wr_data,
	output wire wr_commit,
	output wire wr_busy,
	output wire [`SEBF_ADDR_W-1:0] rd_addr,
	input wire [7:0] rd_data
);

	// ------------------------------------------------------------
	// states, one-hot
	// ------------------------------------------------------------
	localparam [5:0] ST_IDLE = 6'h01; // waiting for START
	localparam [5:0] ST_RX = 6'h02; // shifting in a byte
	localparam [5:0] ST_ACK = 6'h04; // driving acknowledge
	localparam [5:0] ST_TX = 6'h08; // shifting out a byte
	localparam [5:0] ST_MACK = 6'h10; // reading master's ack
	localparam [5:0] ST_WAIT = 6'h20; // not addressed, ignore

	// integer forms first, then cut to the counter widths on purpose
	localparam integer SPIKE_LAST_I = `SEBF_SPIKE_CYC - 1;
	localparam integer HOLD_LOAD_I = `SEBF_HOLD_CYC;
	localparam integer WC_LOAD_I = WC_CYCLES;
	localparam [`SEBF_FLT_W-1:0] SPIKE_LAST =
		SPIKE_LAST_I[`SEBF_FLT_W-1:0];
	localparam [`SEBF_HOLD_W-1:0] HOLD_LOAD =
		HOLD_LOAD_I[`SEBF_HOLD_W-1:0];
	localparam [`SEBF_WC_W-1:0] WC_LOAD = WC_LOAD_I[`SEBF_WC_W-1:0];
	// last count before a down-counter reaches zero
	localparam [`SEBF_HOLD_W-1:0] HOLD_ONE =
		{{(`SEBF_HOLD_W-1){1'b0}}, 1'b1};
	localparam [`SEBF_WC_W-1:0] WC_ONE =
		{{(`SEBF_WC_W-1){1'b0}}, 1'b1};

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	wire [`SEBF_LANES-1:0] pins_raw; // all inputs from outside
	reg [`SEBF_LANES-1:0] sync1_reg; // first stage, only to sync2
	reg [`SEBF_LANES-1:0] sync2_reg;
	reg [`SEBF_LANES-1:0] sync3_reg;
	reg [`SEBF_LANES-1:0] filt_reg; // filtered, glitch-free levels
	reg [`SEBF_FLT_W-1:0] flt_cnt_reg [0:`SEBF_LANES-1];
	reg scl_prev_reg; // filtered scl one cycle back
	reg sda_prev_reg; // filtered sda one cycle back
	wire scl_f; // filtered clock line
	wire sda_f; // filtered data line
	wire scl_rise;
	wire scl_fall;
	wire start_ev;
	wire stop_ev;
	wire [2:0] cs_pins; // chip-select levels, bit 0 first
	wire guard_f; // filtered write guard
	reg [5:0] state_reg;
	reg [3:0] bit_cnt_reg; // bits moved in this byte
	reg [1:0] byte_idx_reg; // control, address hi/lo, data
	reg [7:0] shift_reg; // receive shifter
	reg [7:0] tx_shift_reg; // transmit shifter
	reg rw_reg; // direction from control byte, 1 read
	reg mack_reg; // master acknowledged last byte
	reg data_seen_reg; // a write data byte was accepted
	reg [`SEBF_ADDR_W-1:0] addr_reg; // address pointer
	reg drive_want_reg; // desired pull-down after hold delay
	reg [`SEBF_HOLD_W-1:0] hold_cnt_reg; // cycles until drive applies
	reg sda_oe_reg;
	reg sda_out_reg; // open drain, always low when enabled
	reg busy_reg; // internal write cycle running
	reg [`SEBF_WC_W-1:0] wc_cnt_reg;
	reg commit_reg;
	reg push_reg; // one-cycle push into the buffer
	reg [`SEBF_ADDR_W+7:0] push_word_reg; // {addr, data}
	reg head_valid_reg;
	reg [`SEBF_ADDR_W+7:0] head_reg;
	reg spare_valid_reg;
	reg [`SEBF_ADDR_W+7:0] spare_reg;
	wire buf_in_ready; // buffer has room for one more word
	wire pop;
	wire cs_match;
	wire type_match;
	wire [`SEBF_PAGE_W-1:0] page_next;
	integer i;

	// pads hold chip-selects and guard low when left open
	assign pins_raw = {write_guard_pin, chip_sel_pin_2, chip_sel_pin_1,
		chip_sel_pin_0, sda_pin_in, scl_pin};

	// ------------------------------------------------------------
	// synchroniser and spike filter, one lane per input
	// ------------------------------------------------------------
	// a change is taken only once stages two and three agree and
	// keep agreeing; costs a little latency, rejects short spikes
	always @(posedge ref_clk) begin
		if (reset) begin
			sync1_reg <= `SEBF_SYNC_INIT;
			sync2_reg <= `SEBF_SYNC_INIT;
			sync3_reg <= `SEBF_SYNC_INIT;
			filt_reg <= `SEBF_SYNC_INIT;
			for (i = 0; i < `SEBF_LANES; i = i + 1) begin
				flt_cnt_reg[i] <= {`SEBF_FLT_W{1'b0}};
			end
		end else begin
			sync1_reg <= pins_raw; // R17
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			for (i = 0; i < `SEBF_LANES; i = i + 1) begin
				if (sync2_reg[i] != sync3_reg[i] ||
						sync3_reg[i] == filt_reg[i]) begin
					// disagreement or no change: restart
					flt_cnt_reg[i] <= {`SEBF_FLT_W{1'b0}}; // R12
				end else if (flt_cnt_reg[i] == SPIKE_LAST) begin
					filt_reg[i] <= sync3_reg[i]; // R12
					flt_cnt_reg[i] <= {`SEBF_FLT_W{1'b0}};
				end else begin
					flt_cnt_reg[i] <= flt_cnt_reg[i] + 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// bus condition detection
	// ------------------------------------------------------------
	// edges from previous filtered levels only
	always @(posedge ref_clk) begin
		if (reset) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_prev_reg <= scl_f;
			sda_prev_reg <= sda_f;
		end
	end

	assign scl_f = filt_reg[`SEBF_LN_SCL];
	assign sda_f = filt_reg[`SEBF_LN_SDA];
	assign cs_pins = filt_reg[`SEBF_LN_CS_MSB:`SEBF_LN_CS_LSB];
	assign guard_f = filt_reg[`SEBF_LN_WG];
	assign scl_rise = scl_f & ~scl_prev_reg;
	assign scl_fall = ~scl_f & scl_prev_reg;
	// sda moving while scl stays high is a condition, not data
	assign start_ev = scl_f & scl_prev_reg & sda_prev_reg & ~sda_f; // R5
	assign stop_ev = scl_f & scl_prev_reg & ~sda_prev_reg & sda_f; // R5

	// control byte fields
	assign type_match =
		shift_reg[`SEBF_TYPE_MSB:`SEBF_TYPE_LSB] == DEV_TYPE; // R13
	// each device answers only its own chip-select combination
	assign cs_match =
		shift_reg[`SEBF_CS_MSB:`SEBF_CS_LSB] == cs_pins; // R1 R2 R3
	assign page_next = addr_reg[`SEBF_PAGE_W-1:0] + 1'b1;

	// ------------------------------------------------------------
	// protocol state machine
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (reset) begin
			state_reg <= ST_IDLE; // R18
			bit_cnt_reg <= 4'h0;
			byte_idx_reg <= `SEBF_BYTE_CTRL;
			shift_reg <= 8'h00;
			tx_shift_reg <= 8'h00;
			rw_reg <= 1'b0;
			mack_reg <= 1'b0;
			data_seen_reg <= 1'b0;
			addr_reg <= {`SEBF_ADDR_W{1'b0}};
			drive_want_reg <= 1'b0; // R18
			push_reg <= 1'b0;
			push_word_reg <= {(`SEBF_ADDR_W+8){1'b0}};
		end else begin
			push_reg <= 1'b0;
			if (start_ev) begin
				// start (or repeated start) always restarts decode
				state_reg <= ST_RX;
				bit_cnt_reg <= 4'h0;
				byte_idx_reg <= `SEBF_BYTE_CTRL;
				data_seen_reg <= 1'b0;
				drive_want_reg <= 1'b0;
			end else if (stop_ev) begin
				state_reg <= ST_IDLE;
				data_seen_reg <= 1'b0;
				drive_want_reg <= 1'b0;
			end else begin
				case (state_reg)
				ST_RX: begin
					if (scl_rise) begin
						// sampled on rise; master moves sda only in low
						shift_reg <= {shift_reg[6:0], sda_f}; // R4
						bit_cnt_reg <= bit_cnt_reg + 1'b1;
					end else if (scl_fall &&
							bit_cnt_reg == `SEBF_BITS_PER_BYTE) begin
						bit_cnt_reg <= 4'h0;
						if (byte_idx_reg == `SEBF_BYTE_CTRL) begin
							if (type_match && cs_match && !busy_reg) begin
								rw_reg <= shift_reg[`SEBF_RW_BIT]; // R9
								state_reg <= ST_ACK;
								drive_want_reg <= 1'b1;
							end else begin
								// foreign address or busy: stay silent
								state_reg <= ST_WAIT; // R1 R14
							end
						end else if (byte_idx_reg == `SEBF_BYTE_AHI) begin
							addr_reg[`SEBF_ADDR_W-1:8] <=
								shift_reg[`SEBF_ADDR_HI_W-1:0];
							state_reg <= ST_ACK;
							drive_want_reg <= 1'b1;
						end else if (byte_idx_reg == `SEBF_BYTE_ALO) begin
							addr_reg[7:0] <= shift_reg;
							state_reg <= ST_ACK;
							drive_want_reg <= 1'b1;
						end else if (buf_in_ready) begin
							push_reg <= 1'b1;
							push_word_reg <= {addr_reg, shift_reg};
							// wrap inside the page
							addr_reg[`SEBF_PAGE_W-1:0] <= page_next; // R15
							data_seen_reg <= 1'b1;
							state_reg <= ST_ACK;
							drive_want_reg <= 1'b1;
						end else begin
							// no room: withhold ack rather than lose data
							state_reg <= ST_WAIT;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (rw_reg) begin
							// master chose read: we become transmitter
							state_reg <= ST_TX; // R9
							tx_shift_reg <= rd_data;
							drive_want_reg <= ~rd_data[7];
						end else begin
							state_reg <= ST_RX;
							drive_want_reg <= 1'b0;
							if (byte_idx_reg != `SEBF_BYTE_DATA) begin
								byte_idx_reg <= byte_idx_reg + 1'b1;
							end
						end
						bit_cnt_reg <= 4'h0;
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt_reg == `SEBF_LAST_TX_BIT) begin
							state_reg <= ST_MACK;
							drive_want_reg <= 1'b0;
							addr_reg <= addr_reg + 1'b1;
							bit_cnt_reg <= 4'h0;
						end else begin
							tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
							drive_want_reg <= ~tx_shift_reg[6];
							bit_cnt_reg <= bit_cnt_reg + 1'b1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						mack_reg <= ~sda_f;
					end else if (scl_fall) begin
						if (mack_reg) begin
							state_reg <= ST_TX;
							tx_shift_reg <= rd_data;
							drive_want_reg <= ~rd_data[7];
						end else begin
							// no ack: leave sda high for the stop
							state_reg <= ST_WAIT;
						end
					end
				end
				ST_IDLE, ST_WAIT: begin
					drive_want_reg <= 1'b0;
				end
				default: begin
					state_reg <= ST_IDLE;
					drive_want_reg <= 1'b0;
				end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// sda driver with hold delay after scl fall
	// ------------------------------------------------------------
	// the new level waits out the falling-edge region of scl so a
	// slow edge never looks like a start or stop to other devices
	always @(posedge ref_clk) begin
		if (reset) begin
			hold_cnt_reg <= {`SEBF_HOLD_W{1'b0}};
			sda_oe_reg <= 1'b0; // R18
			sda_out_reg <= 1'b0;
		end else begin
			sda_out_reg <= 1'b0;
			if (start_ev || stop_ev) begin
				hold_cnt_reg <= {`SEBF_HOLD_W{1'b0}};
				sda_oe_reg <= 1'b0;
			end else if (scl_fall) begin
				hold_cnt_reg <= HOLD_LOAD; // R11
			end else if (hold_cnt_reg != {`SEBF_HOLD_W{1'b0}}) begin
				hold_cnt_reg <= hold_cnt_reg - 1'b1;
				if (hold_cnt_reg == HOLD_ONE) begin
					sda_oe_reg <= drive_want_reg; // R11
				end
			end
		end
	end

	// ------------------------------------------------------------
	// internal write cycle timer
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (reset) begin
			busy_reg <= 1'b0;
			wc_cnt_reg <= {`SEBF_WC_W{1'b0}};
			commit_reg <= 1'b0;
		end else begin
			commit_reg <= 1'b0;
			if (busy_reg) begin
				if (wc_cnt_reg == WC_ONE) begin
					busy_reg <= 1'b0; // R10
				end
				wc_cnt_reg <= wc_cnt_reg - 1'b1;
			end else if (stop_ev && data_seen_reg && !rw_reg) begin
				// guard level taken here only; later toggles ignored
				if (!guard_f) begin // R16 R6
					busy_reg <= 1'b1;
					wc_cnt_reg <= WC_LOAD; // R10
					commit_reg <= 1'b1;
				end
				// guard high: no cycle, next command accepted at once
			end
		end
	end

	// ------------------------------------------------------------
	// two-entry write buffer toward the array
	// ------------------------------------------------------------
	// head drives the outputs straight; spare catches one word
	// while the array stalls, so no acknowledged byte is lost
	assign pop = head_valid_reg & wr_ready;
	assign buf_in_ready = ~spare_valid_reg;

	always @(posedge ref_clk) begin
		if (reset) begin
			head_valid_reg <= 1'b0;
			head_reg <= {(`SEBF_ADDR_W+8){1'b0}};
			spare_valid_reg <= 1'b0;
			spare_reg <= {(`SEBF_ADDR_W+8){1'b0}};
		end else if (pop) begin
			if (spare_valid_reg) begin
				head_reg <= spare_reg;
				spare_valid_reg <= push_reg;
				spare_reg <= push_word_reg;
			end else begin
				head_valid_reg <= push_reg;
				head_reg <= push_word_reg;
			end
		end else if (push_reg) begin
			if (!head_valid_reg) begin
				head_valid_reg <= 1'b1;
				head_reg <= push_word_reg;
			end else begin
				spare_valid_reg <= 1'b1;
				spare_reg <= push_word_reg;
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign sda_pin_out = sda_out_reg;
	assign sda_pin_oe = sda_oe_reg;
	assign wr_valid = head_valid_reg;
	assign wr_addr = head_reg[`SEBF_ADDR_W+7:8];
	assign wr_data = head_reg[7:0];
	// array must discard buffered words when commit never comes
	assign wr_commit = commit_reg; // R7
	assign wr_busy = busy_reg;
	assign rd_addr = addr_reg;

endmodule // sebf_slave_front

// ### dv/sebf_bus_master.sv
`timescale 1ns/100ps
// ----------------------------------------
// two-wire bus master model
// ----------------------------------------
// low phase is long on purpose: the slave answers ~500 ns after a fall
module sebf_bus_master (
	input wire sda_line,
	output reg scl_pin,
	output reg sda_low
);
	localparam T_LOW = 810; // low phase in ns, off the system clock grid
	localparam T_HIGH = 330; // high phase in ns
	reg s; // line level sampled mid high phase
	integer k; // bit index
	initial begin
		scl_pin = 1'b1;
		sda_low = 1'b0;
	end
	// one clock pulse; data moves only in the middle of the low phase
	task clk_bit(input b);
		begin
			#(T_LOW / 2) sda_low = !b;
			#(T_LOW / 2) scl_pin = 1'b1;
			#(T_HIGH / 2) s = sda_line;
			#(T_HIGH / 2) scl_pin = 1'b0;
		end
	endtask
	// start: data falls while the clock is high
	task start;
		begin
			#(T_LOW / 2) sda_low = 1'b0;
			#(T_LOW / 2) scl_pin = 1'b1;
			#(T_HIGH) sda_low = 1'b1;
			#(T_HIGH) scl_pin = 1'b0;
		end
	endtask
	// stop: data rises while the clock is high; clock then rests high
	task stop;
		begin
			#(T_LOW / 2) sda_low = 1'b1;
			#(T_LOW / 2) scl_pin = 1'b1;
			#(T_HIGH) sda_low = 1'b0;
			#(T_HIGH);
		end
	endtask
	// byte out msb first, then the slave's acknowledge is read
	task put_byte(input [7:0] v, output ack);
		begin
			for (k = 7; k >= 0; k = k - 1) clk_bit(v[k]);
			clk_bit(1'b1);
			ack = !s;
		end
	endtask
	// byte in msb first, then the master's own acknowledge
	task get_byte(input ack, output [7:0] v);
		begin
			for (k = 7; k >= 0; k = k - 1) begin
				clk_bit(1'b1);
				v[k] = s;
			end
			clk_bit(!ack);
		end
	endtask
	// clock spike shorter than the slave's filter, line resting low
	task spike;
		begin
			#(T_LOW / 4) scl_pin = 1'b1;
			#30 scl_pin = 1'b0;
		end
	endtask
endmodule // sebf_bus_master

// ### dv/sebf_slave_front_assertions.sv
`timescale 1ns/100ps
`include "sebf_regs.vh"
// ----------------------------------------
// port checker for the slave front
// ----------------------------------------
module sebf_front_checker #(
	parameter WC_CYCLES = `SEBF_WC_CYC
) (
	input wire ref_clk,
	input wire reset,
	input wire scl_pin,
	input wire sda_pin_oe,
	input wire write_guard_pin,
	input wire wr_valid,
	input wire wr_ready,
	input wire [`SEBF_ADDR_W-1:0] wr_addr,
	input wire [7:0] wr_data,
	input wire wr_commit,
	input wire wr_busy
);
	// cycles spent in the running write cycle
	reg [`SEBF_WC_W-1:0] busy_cnt_reg;
	always @(posedge ref_clk) begin
		if (reset || !wr_busy) begin
			busy_cnt_reg <= {`SEBF_WC_W{1'b0}};
		end else begin
			busy_cnt_reg <= busy_cnt_reg + 1'b1;
		end
	end
	AST_RESET_IDLE: assert property (@(posedge ref_clk)
		reset |=> !sda_pin_oe && !wr_valid && !wr_busy && !wr_commit)
		else $error("outputs not idle after reset");
	AST_TX_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(sda_pin_oe) |-> !scl_pin && $past(scl_pin, 8) == 1'b0)
		else $error("data driven too soon after clock fall");
	AST_BUSY_LEN: assert property (@(posedge ref_clk) disable iff (reset)
		$fell(wr_busy) |-> busy_cnt_reg >= WC_CYCLES - 1 &&
			busy_cnt_reg <= WC_CYCLES)
		else $error("write cycle length wrong");
	AST_COMMIT_BUSY: assert property (@(posedge ref_clk) disable iff (reset)
		wr_commit |-> ##[0:1] wr_busy)
		else $error("commit without write cycle");
	AST_COMMIT_PULSE: assert property (@(posedge ref_clk) disable iff (reset)
		wr_commit |=> !wr_commit)
		else $error("commit longer than one cycle");
	AST_GUARD: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(wr_busy) |-> $past(write_guard_pin, 8) == 1'b0)
		else $error("write cycle started while guarded");
	AST_NO_ACK_BUSY: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(sda_pin_oe) |-> !wr_busy)
		else $error("line driven during write cycle");
	AST_VALID_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
		wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) &&
			$stable(wr_data))
		else $error("stalled word lost or changed");
endmodule // sebf_front_checker

bind sebf_slave_front sebf_front_checker #(.WC_CYCLES(WC_CYCLES)) u_chk (
	.ref_clk(ref_clk), .reset(reset), .scl_pin(scl_pin),
	.sda_pin_oe(sda_pin_oe), .write_guard_pin(write_guard_pin),
	.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
	.wr_data(wr_data), .wr_commit(wr_commit), .wr_busy(wr_busy)
);

// ### dv/sebf_slave_front_tb.sv
`timescale 1ns/100ps
`include "sebf_regs.vh"
`define CHK(nm, exp, got) \
	begin \
		compares = compares + 1; \
		if ((got) !== (exp)) begin \
			failures = failures + 1; \
			$display("ERROR %s expected %0h seen %0h", nm, exp, got); \
		end \
	end

module sebf_slave_front_tb;
	localparam WC = 400; // short write cycle keeps the run brief
	reg ref_clk = 1'b0;
	reg reset = 1'b1;
	reg [2:0] cs_pins = 3'h0; // open straps modelled as driven low
	reg guard = 1'b0;
	reg wr_ready = 1'b1;
	wire scl, m_low, oe, out, valid, commit, busy;
	wire [`SEBF_ADDR_W-1:0] wr_addr, rd_addr;
	wire [7:0] wr_data;
	wire [7:0] rd_data = rd_addr[7:0] ^ 8'h5a; // array content model
	wire sda = !((oe && !out) || m_low); // wired-and with pull-up
	integer failures = 0;
	integer compares = 0;
	integer commits = 0;
	integer i;
	reg [21:0] words[$]; // words taken by the array
	reg [11:0] rows[0:7]; // straps, control byte, expected ack
	reg a;
	reg [7:0] d;
	always #20 ref_clk = !ref_clk;
	sebf_slave_front #(.WC_CYCLES(WC)) DUT (
		.ref_clk(ref_clk), .reset(reset), .scl_pin(scl),
		.sda_pin_in(sda), .sda_pin_out(out), .sda_pin_oe(oe),
		.chip_sel_pin_0(cs_pins[0]), .chip_sel_pin_1(cs_pins[1]),
		.chip_sel_pin_2(cs_pins[2]), .write_guard_pin(guard),
		.wr_valid(valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
		.wr_data(wr_data), .wr_commit(commit), .wr_busy(busy),
		.rd_addr(rd_addr), .rd_data(rd_data)
	);
	sebf_bus_master m (.sda_line(sda), .scl_pin(scl), .sda_low(m_low));
	// ----------------------------------------
	// array side and helpers
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (valid && wr_ready) words.push_back({wr_addr, wr_data});
		if (commit) commits = commits + 1;
	end
	task send(input [7:0] b, input e);
		begin
			m.put_byte(b, a);
			`CHK("ack", e, a)
		end
	endtask
	// bounded wait; flags are read away from the launching edge
	task wait_busy(input v);
		integer n;
		begin
			n = 0;
			while (busy !== v && n < 1000) begin
				@(negedge ref_clk);
				n = n + 1;
			end
			`CHK("busy", v, busy)
		end
	endtask
	task stop_test;
		begin
			$display("compares %0d failures %0d", compares, failures);
			if (failures == 0 && compares > 0) begin
				$display("ALL CHECKS OK");
			end else begin
				$display("CHECKS NOT OK");
			end
			$finish;
		end
	endtask
	// watchdog well past the expected run length
	initial begin
		repeat (40000) @(posedge ref_clk);
		failures = failures + 1;
		$display("ERROR watchdog expected end seen timeout");
		stop_test;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rows[0] = {3'h0, 8'h50, 1'b1};
		rows[1] = {3'h5, 8'h5a, 1'b1};
		rows[2] = {3'h7, 8'h5e, 1'b1};
		rows[3] = {3'h3, 8'h56, 1'b1};
		rows[4] = {3'h5, 8'h58, 1'b0}; // straps differ
		rows[5] = {3'h2, 8'h54, 1'b1};
		rows[6] = {3'h0, 8'h30, 1'b0}; // wrong type code
		rows[7] = {3'h1, 8'h52, 1'b1};
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (8) @(posedge ref_clk);
		for (i = 0; i < 8; i = i + 1) begin
			@(posedge ref_clk) cs_pins <= rows[i][11:9];
			repeat (4) @(posedge ref_clk);
			m.start;
			send(rows[i][8:1], rows[i][0]);
			m.stop;
		end
		$display("test chip select table done");
		// page write into a stalled array: third word refused, wrap
		@(posedge ref_clk) begin
			cs_pins <= 3'h2;
			wr_ready <= 1'b0;
		end
		m.start;
		send(8'h54, 1'b1);
		send(8'hff, 1'b1);
		send(8'hff, 1'b1);
		send(8'hb1, 1'b1);
		send(8'hb2, 1'b1);
		send(8'hb3, 1'b0);
		m.stop;
		wait_busy(1'b1);
		@(posedge ref_clk) guard <= 1'b1;
		m.start;
		send(8'h54, 1'b0);
		m.stop;
		`CHK("busy after guard", 1'b1, busy)
		`CHK("stalled words", 0, words.size())
		wait_busy(1'b0);
		@(posedge ref_clk) wr_ready <= 1'b1;
		repeat (6) @(negedge ref_clk);
		`CHK("words", 2, words.size())
		`CHK("word 0", {14'h3fff, 8'hb1}, words[0])
		`CHK("word 1", {14'h3fc0, 8'hb2}, words[1])
		`CHK("commits", 1, commits)
		$display("test page write done");
		// guarded write is acknowledged but starts no cycle
		m.start;
		send(8'h54, 1'b1);
		send(8'h00, 1'b1);
		send(8'h10, 1'b1);
		send(8'hc3, 1'b1);
		m.stop;
		repeat (20) @(negedge ref_clk);
		`CHK("guarded busy", 1'b0, busy)
		`CHK("guarded commits", 1, commits)
		`CHK("guarded words", 3, words.size())
		`CHK("word 2", {14'h0010, 8'hc3}, words[2])
		m.start;
		send(8'h54, 1'b1);
		send(8'h12, 1'b1);
		send(8'h34, 1'b1);
		m.stop;
		m.start;
		send(8'h55, 1'b1);
		m.get_byte(1'b1, d);
		`CHK("read 0", 8'h34 ^ 8'h5a, d)
		m.get_byte(1'b0, d);
		`CHK("read 1", 8'h35 ^ 8'h5a, d)
		m.stop;
		@(posedge ref_clk) guard <= 1'b0;
		$display("test guard and read done");
		// a clock spike shorter than the filter must not add a bit
		m.start;
		send(8'h54, 1'b1);
		m.spike;
		send(8'h00, 1'b1);
		m.stop;
		$display("test spike filter done");
		// reset in the middle of a read
		m.start;
		send(8'h55, 1'b1);
		repeat (16) @(posedge ref_clk);
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		@(negedge ref_clk);
		`CHK("line after reset", 1'b0, oe)
		m.stop;
		m.start;
		send(8'h55, 1'b1);
		m.get_byte(1'b0, d);
		`CHK("read after reset", 8'h5a, d)
		m.stop;
		$display("test reset mid read done");
		stop_test;
	end
endmodule // sebf_slave_front_tb
